//--- isabd_consts.vh
// Address, mask, code and reset constants for the ISA master/DMA decoder
`ifndef ISABD_CONSTS_VH
`define ISABD_CONSTS_VH

// Firmware space, low megabyte copy and the two high aliases
`define ISABD_FW_LOW_BASE 32'h000E0000
`define ISABD_FW_HI_ALIAS 32'hFFFE0000
`define ISABD_FW_HI1M_ALIAS 32'hFFEE0000
// Compare mask for a 128K window (bits 31..17)
`define ISABD_FW_128K_MASK 32'hFFFE0000
// Address bit that splits the space into two 64K halves
`define ISABD_FW_HALF_BIT 16

// Utility-bus table: match value and care mask over SA[15:0]
`define ISABD_KBD_A_ADDR 16'h0060
`define ISABD_KBD_A_MASK 16'hFFFD
`define ISABD_KBD_B_ADDR 16'h0064
`define ISABD_KBD_B_MASK 16'hFFFD
`define ISABD_RTC_AS_ADDR 16'h0070
`define ISABD_RTC_AS_MASK 16'hFFF9
`define ISABD_RTC_DAT_ADDR 16'h0071
`define ISABD_RTC_DAT_MASK 16'hFFF9
`define ISABD_DISK_PRI_ADDR 16'h01F0
`define ISABD_DISK_PRI_MASK 16'hFFF8
`define ISABD_DISK_SEC_ADDR 16'h0170
`define ISABD_DISK_SEC_MASK 16'hFFF8
`define ISABD_LPT_ADDR 16'h0278
`define ISABD_LPT_MASK 16'hFFF8
`define ISABD_COM2_ADDR 16'h02F8
`define ISABD_COM2_MASK 16'hFFF8

// Write-only ports whose selected bits are held internally, and port 60h watched on reads
`define ISABD_PORT_70 16'h0070
`define ISABD_PORT_372 16'h0372
`define ISABD_PORT_3F2 16'h03F2
`define ISABD_PORT_60 16'h0060
`define ISABD_FULL_MASK 16'hFFFF
// Bits of each write-only port kept in the shadow copies
`define ISABD_SHADOW_70_MASK 8'h80
`define ISABD_SHADOW_372_MASK 8'h0F
`define ISABD_SHADOW_3F2_MASK 8'h0F
`define ISABD_SHADOW_RST 8'h00

// Encoded chip-select codes
`define ISABD_CS_FIRMWARE 4'h0
`define ISABD_CS_KEYBOARD 4'h1
`define ISABD_CS_CLK_STROBE 4'h2
`define ISABD_CS_CLK_DATA 4'h3
`define ISABD_CS_DISK_CMD 4'h4
`define ISABD_CS_PARALLEL 4'h5
`define ISABD_CS_SERIAL_TWO 4'h6
`define ISABD_CS_IDLE 4'hF

// Select enable vector bit positions
`define ISABD_EN_KEYBOARD 0
`define ISABD_EN_CLK_STROBE 1
`define ISABD_EN_CLK_DATA 2
`define ISABD_EN_DISK_CMD 3
`define ISABD_EN_PARALLEL 4
`define ISABD_EN_SERIAL_TWO 5
`define ISABD_EN_WIDTH 6

`endif

//--- isabd_cs_match.v
// One masked address compare of the utility-bus chip-select table
`timescale 1ns/1ps
module isabd_cs_match #(
   parameter [15:0] MATCH = 16'h0000,
   parameter [15:0] CARE = 16'hFFFF
) (
   input wire [15:0] addr,
   input wire enable,
   output wire hit
);

   // Cleared CARE bits are the table's don't-care positions
   assign hit = enable & ((addr & CARE) == (MATCH & CARE));

endmodule // isabd_cs_match

//--- isabd_decode.v
// ISA master/DMA address decoder: firmware, utility selects, port shadows
`timescale 1ns/1ps
`include "isabd_consts.vh"
module isabd_decode (
   core_clk,
   rst,
   sa,
   la_hi,
   ior_n,
   iow_n,
   memr_n,
   memw_n,
   isa_master_cycle,
   dma_cycle,
   refresh_n,
   sd_in,
   int_reg_hit,
   int_reg_excluded,
   pci_addr,
   pci_mem_cycle,
   top_bios_positive_decode,
   low_bios_enable,
   fwd_low_to_pci,
   fwd_low_override,
   select_enable,
   cs_code,
   firmware_chip_select_enc,
   forward_to_pci,
   contain_to_isa,
   int_reg_cycle_8bit,
   pci_top_bios_positive,
   pci_top_bios_subtractive,
   iochrdy_out,
   iochrdy_oe_n,
   kbd_read_seen,
   shadow_port70,
   shadow_port372,
   shadow_port3f2
);

   input wire core_clk;
   input wire rst;
   input wire [19:0] sa;
   input wire [31:20] la_hi;
   input wire ior_n;
   input wire iow_n;
   input wire memr_n;
   input wire memw_n;
   input wire isa_master_cycle;
   input wire dma_cycle;
   input wire refresh_n;
   input wire [7:0] sd_in;
   input wire int_reg_hit;
   input wire int_reg_excluded;
   input wire [31:16] pci_addr;
   input wire pci_mem_cycle;
   input wire top_bios_positive_decode;
   input wire low_bios_enable;
   input wire fwd_low_to_pci;
   input wire fwd_low_override;
   input wire [`ISABD_EN_WIDTH-1:0] select_enable;
   output reg [3:0] cs_code;
   output reg firmware_chip_select_enc;
   output reg forward_to_pci;
   output reg contain_to_isa;
   output reg int_reg_cycle_8bit;
   output reg pci_top_bios_positive;
   output reg pci_top_bios_subtractive;
   output wire iochrdy_out;
   output wire iochrdy_oe_n;
   output wire kbd_read_seen;
   output wire [7:0] shadow_port70;
   output wire [7:0] shadow_port372;
   output wire [7:0] shadow_port3f2;

   localparam [31:0] FW_LOW = `ISABD_FW_LOW_BASE;
   localparam [31:0] FW_HI = `ISABD_FW_HI_ALIAS;
   localparam [31:0] FW_HI1M = `ISABD_FW_HI1M_ALIAS;
   localparam [31:0] FW_MASK = `ISABD_FW_128K_MASK;

   wire [31:0] isa_addr;
   wire [31:0] pci_full;
   wire [15:0] io_addr;
   wire mem_cycle;
   wire io_rd;
   wire io_wr;
   wire fw_low_win;
   wire fw_upper_half;
   wire fw_lower_half;
   wire fw_select_ok;
   wire pci_upper_hit;
   wire hit_kbd_a;
   wire hit_kbd_b;
   wire hit_clk_strobe;
   wire hit_clk_data;
   wire hit_disk_pri;
   wire hit_disk_sec;
   wire hit_lpt;
   wire hit_com2;
   wire hit_p70;
   wire hit_p372;
   wire hit_p3f2;
   wire hit_p60;
   wire shadow_wr;

   reg ready_drive_ff;
   reg nxt_ready_drive;
   reg iow_prev_ff;
   reg ior_prev_ff;
   reg kbd_read_ff;
   reg nxt_kbd_read;
   reg [7:0] shadow70_ff;
   reg [7:0] shadow372_ff;
   reg [7:0] shadow3f2_ff;
   reg [7:0] nxt_shadow70;
   reg [7:0] nxt_shadow372;
   reg [7:0] nxt_shadow3f2;

   // LA lines above the megabyte come latched from the cycle start
   assign isa_addr = {la_hi, sa};
   assign pci_full = {pci_addr, 16'h0000};
   assign io_addr = sa[15:0];
   assign mem_cycle = ~memr_n | ~memw_n;
   assign io_rd = ~ior_n;
   assign io_wr = ~iow_n;

   // Only the low window is decoded for ISA masters and DMA
   assign fw_low_win = ((isa_addr & FW_MASK) == FW_LOW);
   assign fw_upper_half = fw_low_win & isa_addr[`ISABD_FW_HALF_BIT];
   assign fw_lower_half = fw_low_win & ~isa_addr[`ISABD_FW_HALF_BIT];
   // Refresh and DMA cycles never see the firmware select
   assign fw_select_ok = refresh_n & ~dma_cycle;

   // PCI side sees the upper half in every copy of the space
   assign pci_upper_hit = pci_full[`ISABD_FW_HALF_BIT] &
      (((pci_full & FW_MASK) == FW_LOW) |
       ((pci_full & FW_MASK) == FW_HI) |
       ((pci_full & FW_MASK) == FW_HI1M));

   // Utility-bus table, one compare per row group
   isabd_cs_match #(.MATCH(`ISABD_KBD_A_ADDR), .CARE(`ISABD_KBD_A_MASK))
   u_kbd_a (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_KEYBOARD] & (io_rd | io_wr)),
      .hit(hit_kbd_a)
   );

   isabd_cs_match #(.MATCH(`ISABD_KBD_B_ADDR), .CARE(`ISABD_KBD_B_MASK))
   u_kbd_b (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_KEYBOARD] & (io_rd | io_wr)),
      .hit(hit_kbd_b)
   );

   // Address strobe only on writes
   isabd_cs_match #(.MATCH(`ISABD_RTC_AS_ADDR), .CARE(`ISABD_RTC_AS_MASK))
   u_clk_strobe (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_CLK_STROBE] & io_wr),
      .hit(hit_clk_strobe)
   );

   isabd_cs_match #(.MATCH(`ISABD_RTC_DAT_ADDR), .CARE(`ISABD_RTC_DAT_MASK))
   u_clk_data (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_CLK_DATA] & (io_rd | io_wr)),
      .hit(hit_clk_data)
   );

   isabd_cs_match #(.MATCH(`ISABD_DISK_PRI_ADDR), .CARE(`ISABD_DISK_PRI_MASK))
   u_disk_pri (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_DISK_CMD] & (io_rd | io_wr)),
      .hit(hit_disk_pri)
   );

   isabd_cs_match #(.MATCH(`ISABD_DISK_SEC_ADDR), .CARE(`ISABD_DISK_SEC_MASK))
   u_disk_sec (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_DISK_CMD] & (io_rd | io_wr)),
      .hit(hit_disk_sec)
   );

   isabd_cs_match #(.MATCH(`ISABD_LPT_ADDR), .CARE(`ISABD_LPT_MASK))
   u_lpt (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_PARALLEL] & (io_rd | io_wr)),
      .hit(hit_lpt)
   );

   isabd_cs_match #(.MATCH(`ISABD_COM2_ADDR), .CARE(`ISABD_COM2_MASK))
   u_com2 (
      .addr(io_addr),
      .enable(select_enable[`ISABD_EN_SERIAL_TWO] & (io_rd | io_wr)),
      .hit(hit_com2)
   );

   // Exact-address compares for the shadowed and monitored ports
   isabd_cs_match #(.MATCH(`ISABD_PORT_70), .CARE(`ISABD_FULL_MASK))
   u_p70 (
      .addr(io_addr),
      .enable(isa_master_cycle & io_wr),
      .hit(hit_p70)
   );

   isabd_cs_match #(.MATCH(`ISABD_PORT_372), .CARE(`ISABD_FULL_MASK))
   u_p372 (
      .addr(io_addr),
      .enable(isa_master_cycle & io_wr),
      .hit(hit_p372)
   );

   isabd_cs_match #(.MATCH(`ISABD_PORT_3F2), .CARE(`ISABD_FULL_MASK))
   u_p3f2 (
      .addr(io_addr),
      .enable(isa_master_cycle & io_wr),
      .hit(hit_p3f2)
   );

   isabd_cs_match #(.MATCH(`ISABD_PORT_60), .CARE(`ISABD_FULL_MASK))
   u_p60 (
      .addr(io_addr),
      .enable(io_rd),
      .hit(hit_p60)
   );

   // Decode is combinational so selects track the address without delay
   always @*
   begin
      cs_code = `ISABD_CS_IDLE;
      firmware_chip_select_enc = 1'b0;
      forward_to_pci = 1'b0;
      contain_to_isa = 1'b1;
      int_reg_cycle_8bit = 1'b0;
      pci_top_bios_positive = 1'b0;
      pci_top_bios_subtractive = 1'b0;
      if (mem_cycle & fw_upper_half)
      begin
         // Upper half is always enabled
         firmware_chip_select_enc = fw_select_ok;
      end
      else if (mem_cycle & fw_lower_half)
      begin
         if (low_bios_enable)
         begin
            firmware_chip_select_enc = fw_select_ok;
         end
         else if (fwd_low_to_pci | fwd_low_override)
         begin
            forward_to_pci = 1'b1;
            contain_to_isa = 1'b0;
         end
      end
      if (firmware_chip_select_enc)
      begin
         cs_code = `ISABD_CS_FIRMWARE;
      end
      else if (hit_kbd_a | hit_kbd_b)
      begin
         cs_code = `ISABD_CS_KEYBOARD;
      end
      else if (hit_clk_strobe)
      begin
         cs_code = `ISABD_CS_CLK_STROBE;
      end
      else if (hit_clk_data)
      begin
         cs_code = `ISABD_CS_CLK_DATA;
      end
      else if (hit_disk_pri | hit_disk_sec)
      begin
         cs_code = `ISABD_CS_DISK_CMD;
      end
      else if (hit_lpt)
      begin
         cs_code = `ISABD_CS_PARALLEL;
      end
      else if (hit_com2)
      begin
         cs_code = `ISABD_CS_SERIAL_TWO;
      end
      // Excluded registers fall through to ISA like any other cycle
      if (isa_master_cycle & int_reg_hit & ~int_reg_excluded)
      begin
         int_reg_cycle_8bit = 1'b1;
      end
      if (pci_mem_cycle & pci_upper_hit)
      begin
         pci_top_bios_positive = top_bios_positive_decode;
         pci_top_bios_subtractive = ~top_bios_positive_decode;
      end
   end

   // Shadow capture on the first cycle of the write strobe only
   assign shadow_wr = io_wr & iow_prev_ff;

   always @*
   begin
      nxt_shadow70 = shadow70_ff;
      nxt_shadow372 = shadow372_ff;
      nxt_shadow3f2 = shadow3f2_ff;
      // Ready is driven for the whole write strobe, never for 60h reads
      nxt_ready_drive = hit_p70 | hit_p372 | hit_p3f2;
      nxt_kbd_read = isa_master_cycle & hit_p60 & ior_prev_ff;
      if (shadow_wr & hit_p70)
      begin
         nxt_shadow70 = sd_in & `ISABD_SHADOW_70_MASK;
      end
      if (shadow_wr & hit_p372)
      begin
         nxt_shadow372 = sd_in & `ISABD_SHADOW_372_MASK;
      end
      if (shadow_wr & hit_p3f2)
      begin
         nxt_shadow3f2 = sd_in & `ISABD_SHADOW_3F2_MASK;
      end
   end

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         ready_drive_ff <= 1'b0;
         iow_prev_ff <= 1'b1;
         ior_prev_ff <= 1'b1;
         kbd_read_ff <= 1'b0;
         shadow70_ff <= `ISABD_SHADOW_RST;
         shadow372_ff <= `ISABD_SHADOW_RST;
         shadow3f2_ff <= `ISABD_SHADOW_RST;
      end
      else
      begin
         ready_drive_ff <= nxt_ready_drive;
         iow_prev_ff <= iow_n;
         ior_prev_ff <= ior_n;
         kbd_read_ff <= nxt_kbd_read;
         shadow70_ff <= nxt_shadow70;
         shadow372_ff <= nxt_shadow372;
         shadow3f2_ff <= nxt_shadow3f2;
      end
   end

   // Open-drain style ready: enable low while driving the ready level
   assign iochrdy_out = ready_drive_ff;
   assign iochrdy_oe_n = ~ready_drive_ff;
   assign kbd_read_seen = kbd_read_ff;
   assign shadow_port70 = shadow70_ff;
   assign shadow_port372 = shadow372_ff;
   assign shadow_port3f2 = shadow3f2_ff;

endmodule // isabd_decode

//--- isabd_decode_sva.sv
// Concurrent checks on the ISA master/DMA decoder ports
`timescale 1ns/1ps
module isabd_decode_chk (
   input wire core_clk,
   input wire rst,
   input wire [19:0] sa,
   input wire [31:20] la_hi,
   input wire iow_n,
   input wire memr_n,
   input wire isa_master_cycle,
   input wire dma_cycle,
   input wire refresh_n,
   input wire [7:0] sd_in,
   input wire low_bios_enable,
   input wire [5:0] select_enable,
   input wire [3:0] cs_code,
   input wire firmware_chip_select_enc,
   input wire forward_to_pci,
   input wire contain_to_isa,
   input wire iochrdy_out,
   input wire iochrdy_oe_n,
   input wire [7:0] shadow_port3f2
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Only the first low sample counts, so a held strobe is one write
   sequence s_wr_3f2;
      $fell(iow_n) && isa_master_cycle && sa[15:0] == 16'h03F2;
   endsequence
   sequence s_fw_top;
      !memr_n && isa_master_cycle && !dma_cycle && refresh_n &&
      la_hi == 12'h000 && sa[19:16] == 4'hF;
   endsequence
   a_fw_top_hit: assert property (
      s_fw_top |-> firmware_chip_select_enc && cs_code == 4'h0)
      else $error("firmware select missing in upper half");
   a_fw_quiet_dma: assert property (
      !refresh_n || dma_cycle |-> !firmware_chip_select_enc)
      else $error("firmware select during refresh or dma");
   a_fw_low_off: assert property (
      sa[19:16] == 4'hE && !low_bios_enable |-> !firmware_chip_select_enc)
      else $error("firmware select in disabled lower half");
   a_route_one_way: assert property (
      forward_to_pci != contain_to_isa)
      else $error("cycle both or neither forwarded and contained");
   a_serial_two_off: assert property (
      !select_enable[5] |-> cs_code != 4'h6)
      else $error("disabled serial select produced");
   a_rdy_drive: assert property (
      s_wr_3f2 |-> ##[1:2] (!iochrdy_oe_n && iochrdy_out))
      else $error("ready not driven for port write");
   a_shadow_update: assert property (
      s_wr_3f2 |-> ##[1:2] shadow_port3f2 == (sd_in & 8'h0F))
      else $error("port shadow not updated");
   a_rdy_release: assert property (
      $rose(iow_n) |-> ##[1:2] iochrdy_oe_n)
      else $error("ready held after write ended");
endmodule // isabd_decode_chk

bind isabd_decode isabd_decode_chk u_chk (.core_clk(core_clk), .rst(rst),
   .sa(sa), .la_hi(la_hi), .iow_n(iow_n), .memr_n(memr_n),
   .isa_master_cycle(isa_master_cycle), .dma_cycle(dma_cycle),
   .refresh_n(refresh_n), .sd_in(sd_in), .low_bios_enable(low_bios_enable),
   .select_enable(select_enable), .cs_code(cs_code),
   .firmware_chip_select_enc(firmware_chip_select_enc),
   .forward_to_pci(forward_to_pci), .contain_to_isa(contain_to_isa),
   .iochrdy_out(iochrdy_out), .iochrdy_oe_n(iochrdy_oe_n),
   .shadow_port3f2(shadow_port3f2));

//--- isabd_isa_master.sv
// ISA bus master model driving cycles into the decoder
`timescale 1ns/1ps
module isabd_isa_master (
   input wire core_clk,
   output reg [19:0] sa,
   output reg [31:20] la_hi,
   output reg ior_n,
   output reg iow_n,
   output reg memr_n,
   output reg isa_master_cycle,
   output reg dma_cycle,
   output reg refresh_n,
   output reg [7:0] sd_in
);
   initial
   begin
      sa = 20'h00000;
      la_hi = 12'h000;
      ior_n = 1'h1;
      iow_n = 1'h1;
      memr_n = 1'h1;
      isa_master_cycle = 1'h0;
      dma_cycle = 1'h0;
      refresh_n = 1'h1;
      sd_in = 8'h00;
   end
   task io_start(input [15:0] a, input wr, input [7:0] d);
   begin
      @(posedge core_clk);
      isa_master_cycle <= 1'h1;
      la_hi <= 12'h000;
      sa <= {4'h0, a};
      sd_in <= d;
      iow_n <= !wr;
      ior_n <= wr;
   end
   endtask
   task mem_start(input [31:0] a, input dma, input refr);
   begin
      @(posedge core_clk);
      isa_master_cycle <= !dma && !refr;
      dma_cycle <= dma;
      refresh_n <= !refr;
      la_hi <= a[31:20];
      sa <= a[19:0];
      memr_n <= 1'h0;
   end
   endtask
   task idle;
   begin
      @(posedge core_clk);
      ior_n <= 1'h1;
      iow_n <= 1'h1;
      memr_n <= 1'h1;
      isa_master_cycle <= 1'h0;
      dma_cycle <= 1'h0;
      refresh_n <= 1'h1;
      // Released data line must not keep showing the last byte
      sd_in <= ~sd_in;
   end
   endtask
endmodule // isabd_isa_master

//--- tb_top.sv
// Self-checking testbench for the ISA master/DMA decoder
`timescale 1ns/1ps
module tb_top;
   localparam [279:0] TBL = {16'h0064, 4'h1, 16'h0070, 4'h2, 16'h0076, 4'h2,
      16'h0071, 4'h3, 16'h0077, 4'h3, 16'h01F0, 4'h4, 16'h01F7, 4'h4,
      16'h0170, 4'h4, 16'h0177, 4'h4, 16'h0278, 4'h5, 16'h027F, 4'h5,
      16'h02F8, 4'h6, 16'h02FF, 4'h6, 16'h0100, 4'hF};
   localparam [47:0] PORTS = {16'h0070, 16'h0372, 16'h03F2};
   reg core_clk = 1'h0;
   reg rst = 1'h1;
   reg [31:16] pci_addr = 16'h0000;
   reg pci_mem_cycle = 1'h0;
   reg top_bios_positive_decode = 1'h0;
   reg low_bios_enable = 1'h0;
   reg fwd_low_to_pci = 1'h0;
   reg fwd_low_override = 1'h0;
   reg [5:0] select_enable = 6'h00;
   reg int_reg_hit = 1'h0;
   reg int_reg_excluded = 1'h0;
   wire [19:0] sa;
   wire [31:20] la_hi;
   wire ior_n, iow_n, memr_n, isa_master_cycle, dma_cycle, refresh_n;
   wire [7:0] sd_in, shadow_port70, shadow_port372, shadow_port3f2;
   wire [3:0] cs_code;
   wire fw, forward_to_pci, contain_to_isa, int_reg_cycle_8bit;
   wire pci_pos, pci_sub, iochrdy_out, iochrdy_oe_n, kbd_read_seen;
   integer fails = 0;
   integer num_checks = 0;
   integer i;
   reg e_fwd;
   reg [19:0] ent;
   reg [2:0] cnt;
   isabd_isa_master m0 (.core_clk(core_clk), .sa(sa), .la_hi(la_hi),
      .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n),
      .isa_master_cycle(isa_master_cycle), .dma_cycle(dma_cycle),
      .refresh_n(refresh_n), .sd_in(sd_in));
   isabd_decode uut (.core_clk(core_clk), .rst(rst), .sa(sa), .la_hi(la_hi),
      .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(1'h1),
      .isa_master_cycle(isa_master_cycle), .dma_cycle(dma_cycle),
      .refresh_n(refresh_n), .sd_in(sd_in), .int_reg_hit(int_reg_hit),
      .int_reg_excluded(int_reg_excluded), .pci_addr(pci_addr),
      .pci_mem_cycle(pci_mem_cycle),
      .top_bios_positive_decode(top_bios_positive_decode),
      .low_bios_enable(low_bios_enable), .fwd_low_to_pci(fwd_low_to_pci),
      .fwd_low_override(fwd_low_override), .select_enable(select_enable),
      .cs_code(cs_code), .firmware_chip_select_enc(fw),
      .forward_to_pci(forward_to_pci), .contain_to_isa(contain_to_isa),
      .int_reg_cycle_8bit(int_reg_cycle_8bit),
      .pci_top_bios_positive(pci_pos), .pci_top_bios_subtractive(pci_sub),
      .iochrdy_out(iochrdy_out), .iochrdy_oe_n(iochrdy_oe_n),
      .kbd_read_seen(kbd_read_seen), .shadow_port70(shadow_port70),
      .shadow_port372(shadow_port372), .shadow_port3f2(shadow_port3f2));
   always #5 core_clk = ~core_clk;
   task chk(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
      end
   end
   endtask
   task cfg(input [3:0] b, input [5:0] en, input [1:0] ir);
   begin
      @(posedge core_clk);
      low_bios_enable <= b[0];
      fwd_low_to_pci <= b[1];
      fwd_low_override <= b[2];
      top_bios_positive_decode <= b[3];
      select_enable <= en;
      int_reg_hit <= ir[0];
      int_reg_excluded <= ir[1];
      pci_mem_cycle <= 1'h1;
      pci_addr <= 16'hFFFF;
   end
   endtask
   task final_report;
   begin
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      #1;
      chk("shadows", {shadow_port70, shadow_port372, shadow_port3f2},
         0);
      for (i = 0; i < 16; i = i + 1)
      begin
         cfg(i[3:0], 6'h3F, 2'h0);
         m0.mem_start(32'h000F0000 + i, 1'h0, 1'h0);
         #1;
         chk("fw top", {fw, cs_code, contain_to_isa}, 6'h21);
         chk("pci top", {pci_pos, pci_sub}, {i[3], !i[3]});
         m0.mem_start(32'h000E8000, 1'h0, 1'h0);
         #1;
         e_fwd = !i[0] && (i[1] || i[2]);
         chk("fw low", {fw, forward_to_pci}, {i[0], e_fwd});
      end
      for (i = 0; i < 3; i = i + 1)
      begin
         m0.mem_start(i == 0 ? 32'hFFFE0000 : 32'h000F0000, i == 1, i == 2);
         #1;
         chk("fw none", {fw, contain_to_isa}, 2'h1);
      end
      m0.idle;
      // Second pass with every select turned off must show the idle code
      for (i = 0; i < 28; i = i + 1)
      begin
         if (i == 0 || i == 14)
            cfg(4'h1, i == 0 ? 6'h3F : 6'h00, 2'h0);
         ent = TBL[20 * (13 - i % 14) +: 20];
         m0.io_start(ent[19:4], 1'h1, 8'h00);
         #1;
         if (i < 14)
            chk("cs", cs_code, ent[3:0]);
         else
            chk("cs off", cs_code, 4'hF);
         m0.idle;
      end
      for (i = 0; i < 3; i = i + 1)
      begin
         m0.io_start(PORTS[16 * i +: 16], 1'h1, 8'hA5);
         repeat (2) @(posedge core_clk);
         #1;
         chk("rdy on", {iochrdy_oe_n, iochrdy_out}, 2'h1);
         m0.idle;
         repeat (3) @(posedge core_clk);
         #1;
         chk("rdy off", iochrdy_oe_n, 1'h1);
      end
      chk("shadows", {shadow_port70, shadow_port372, shadow_port3f2},
         24'h800505);
      m0.io_start(16'h0060, 1'h0, 8'h00);
      cnt = 3'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge core_clk);
         #1;
         cnt = cnt + kbd_read_seen;
         chk("kbd rdy", iochrdy_oe_n, 1'h1);
      end
      chk("kbd pulse", cnt, 3'h1);
      m0.idle;
      for (i = 0; i < 2; i = i + 1)
      begin
         cfg(4'h1, 6'h3F, {i[0], 1'h1});
         m0.io_start(16'h0022, 1'h1, 8'h00);
         #1;
         chk("reg 8bit", int_reg_cycle_8bit, !i[0]);
         m0.idle;
      end
      // Reads: strobe row is write-only, data row answers both
      for (i = 0; i < 2; i = i + 1)
      begin
         m0.io_start(i ? 16'h0071 : 16'h0070, 1'h0, 8'h00);
         #1;
         chk("cs read", cs_code, i ? 4'h3 : 4'hF);
         m0.idle;
      end
      final_report;
   end
endmodule // tb_top
